// >>> include/cms_pkg.sv
// Purpose: Shared constants for the configuration mode select block
// Assumes: Byte-wide register bus, one clock domain
// Notes:   Register offsets and reset values are local to this block

package cms_pkg;

    // Register bus widths
    localparam int REG_AW = 8;
    localparam int REG_DW = 8;
    localparam int TRIM_W = 3;

    // Register offsets
    localparam logic [7:0] OFS_CTL  = 8'h08;
    localparam logic [7:0] OFS_TRIM = 8'h09;
    localparam logic [7:0] OFS_OUT  = 8'h0A;
    localparam logic [7:0] OFS_STAT = 8'h0B;

    // Control register fields
    localparam int CTL_PWR_UP_BIT = 0;
    localparam int CTL_EDGE_BIT   = 1;
    localparam int CTL_BUS24_BIT  = 2;
    localparam int CTL_DIFF_BIT   = 3;
    localparam int CTL_DESKEW_BIT = 4;
    localparam int CTL_USED_W     = 5;

    // Output and status register fields
    localparam int OUT_PROG_BIT    = 0;
    localparam int STAT_HOT_PLUG_DETECT_IN_BIT  = 0;
    localparam int STAT_RXSNS_BIT  = 1;

    // Reset values: power-up bit clear means powered down
    localparam logic [7:0]        CTL_RST  = 8'h00;
    localparam logic [TRIM_W-1:0] TRIM_RST = 3'h4;
    localparam logic [7:0]        OUT_RST  = 8'h00;

    // Positions inside the synchronised pin vector
    localparam int PIN_EDGE  = 0;
    localparam int PIN_BUS_WIDTH_SELECT  = 1;
    localparam int PIN_CLOCK_MODE_SELECT  = 2;
    localparam int PIN_PDN   = 3;
    localparam int PIN_DESKEW_ENABLE_PIN  = 4;
    localparam int PIN_TRIM  = 5;
    localparam int PIN_VREFL = 8;
    localparam int PIN_RXDET = 9;
    localparam int PIN_W     = 10;

    // Serial slave states
    typedef enum logic [6:0] {
        SER_IDLE = 7'b000_0001,
        SER_ADDR = 7'b000_0010,
        SER_ACK  = 7'b000_0100,
        SER_SUB  = 7'b000_1000,
        SER_DATA = 7'b001_0000,
        SER_READ = 7'b010_0000,
        SER_RACK = 7'b100_0000
    } cms_ser_state_t;

endpackage

// >>> hw/cms_sync.sv
// Purpose: Two-flop synchroniser for a vector of slow levels
// Assumes: Each bit is an independent level
// Notes:   Bits of a field may settle one cycle apart

`timescale 1ns/1ps

module cms_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;

    if (WIDTH < 1) begin : g_chk
        $error("cms_sync WIDTH must be at least 1");
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule // cms_sync

// >>> hw/cms_ctrl.sv
// Purpose: Selects pin-strap or serial-register configuration for the transmitter
// Assumes: CLOCK is the input pixel clock; pins are slow levels
// Notes:   Serial logic is held reset while INTERFACE_SELECT is low
//
// Function
// - Select low: serial interface off, configuration from strap pins.
// - Select high: serial interface on, configuration from registers with defaults.
// - Select low asynchronously resets serial logic, no clock needed.
// - Select low then high resets state machine and reloads all defaults.
// - Pin mode: edge pin high latches on rising, low on falling.
// - Latch edge choice same for single-ended and differential clock.
// - Serial mode: edge pin becomes hot-plug detect input, monitored.
// - Pin mode: clock-mode, bus-width, reference level choose clock input style.
// - Serial mode: clock-mode pin is serial data, open-drain only.
// - Pin mode: monitor sense high when powered receiver detected, else low.
// - Serial mode: monitor sense follows host-programmed value.
// - Monitor sense output is open-drain in both modes.
// - Pin mode: power-down pin high normal, low power-down.
// - Power-down keeps only I/O buffers and serial interface active.
// - Serial mode: power-down from register, pin ignored.
// - Power-down register resets to powered-down on every serial reset.
// - Pin mode: bus-width pin high 24-bit single edge, low 12-bit dual.
// - Pin mode: deskew pin high uses trim pins, low default trim.

`timescale 1ns/1ps

module cms_ctrl
    import cms_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR    = 7'h38,
    parameter int         TRIM_WIDTH  = cms_pkg::TRIM_W
) (
    input  wire logic                        CLOCK,
    input  wire logic                        RESET_N,
    input  wire logic                        INTERFACE_SELECT,
    input  wire logic                        LATCH_EDGE_HOT_PLUG,
    input  wire logic                        BUS_WIDTH_SCL,
    input  wire logic                        CLOCK_MODE_SDA_I,
    output logic                             CLOCK_MODE_SDA_O,
    output logic                             CLOCK_MODE_SDA_OE,
    input  wire logic                        POWER_DOWN_N,
    input  wire logic                        DESKEW_ENABLE_PIN,
    input  wire logic [cms_pkg::TRIM_W-1:0]  DESKEW_TRIM_PINS,
    input  wire logic                        VREF_LOW_SWING,
    input  wire logic                        RECEIVER_DETECT,
    output logic                             MONITOR_SENSE_OUT_O,
    output logic                             MONITOR_SENSE_OUT_OE,
    input  wire logic [cms_pkg::REG_AW-1:0]  REG_ADDR,
    input  wire logic [cms_pkg::REG_DW-1:0]  REG_WDATA,
    input  wire logic                        REG_WR,
    input  wire logic                        REG_RD,
    output logic      [cms_pkg::REG_DW-1:0]  REG_RDATA,
    output logic                             CFG_LATCH_RISING,
    output logic                             CFG_BUS_24BIT,
    output logic                             CFG_CLOCK_DIFF,
    output logic                             CFG_DESKEW_EN,
    output logic      [cms_pkg::TRIM_W-1:0]  CFG_DESKEW_TRIM,
    output logic                             CORE_ENABLE,
    output logic                             HOT_PLUG_DETECTED,
    output logic                             SERIAL_ACTIVE
);
    import cms_pkg::*;

    if (TRIM_WIDTH != TRIM_W) begin : g_chk
        $error("cms_ctrl TRIM_WIDTH must match the trim field");
    end

    logic                 ser_rst_n;
    assign ser_rst_n = RESET_N & INTERFACE_SELECT;

    logic [PIN_W-1:0]     pins_raw;
    logic [PIN_W-1:0]     pins_s;
    logic [1:0]           bus_s;
    logic                 interface_select_s;

    logic                 scl_q;
    logic                 sda_q;
    logic                 scl_rise;
    logic                 scl_fall;
    logic                 start_det;
    logic                 stop_det;

    cms_ser_state_t       st_r;
    cms_ser_state_t       ack_next_r;
    logic [2:0]           bitcnt_r;
    logic [7:0]           shift_r;
    logic [7:0]           tx_r;
    logic [7:0]           sub_r;
    logic                 nack_r;
    logic                 sda_drive_r;
    logic                 addr_bit_r;
    logic [7:0]           rd_sub;

    logic [7:0]           ctl_r;
    logic [TRIM_W-1:0]    trim_r;
    logic [7:0]           out_r;

    logic                 ser_wr;
    logic                 wr_en;
    logic [7:0]           wr_addr;
    logic [7:0]           wr_data;

    logic                 pin_diff;

    function automatic logic [7:0] rd_byte(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            OFS_CTL:  v = {{(8 - CTL_USED_W){1'b0}}, ctl_r[CTL_USED_W-1:0]};
            OFS_TRIM: v = {{(8 - TRIM_W){1'b0}}, trim_r};
            OFS_OUT:  v = {7'h00, out_r[OUT_PROG_BIT]};
            OFS_STAT: v = {6'h00, pins_s[PIN_RXDET], pins_s[PIN_EDGE]};
            default:  v = 8'h00;
        endcase
        return v;
    endfunction

    always_comb rd_sub = rd_byte(sub_r);

    assign pins_raw = {RECEIVER_DETECT, VREF_LOW_SWING, DESKEW_TRIM_PINS, DESKEW_ENABLE_PIN,
                       POWER_DOWN_N, CLOCK_MODE_SDA_I, BUS_WIDTH_SCL, LATCH_EDGE_HOT_PLUG};

    cms_sync #(.WIDTH(PIN_W)) u_pin_sync (
        .clk   (CLOCK),
        .rst_n (RESET_N),
        .d     (pins_raw),
        .q     (pins_s)
    );

    // Mode select level gets its own pair; the raw level drives the reset and also gates the mode muxes with it
    cms_sync #(.WIDTH(1)) u_sel_sync (
        .clk   (CLOCK),
        .rst_n (RESET_N),
        .d     (INTERFACE_SELECT),
        .q     (interface_select_s)
    );

    assign bus_s = {pins_s[PIN_CLOCK_MODE_SELECT], pins_s[PIN_BUS_WIDTH_SELECT]};

    // Edge history of the synchronised serial lines
    always_ff @(posedge CLOCK or negedge ser_rst_n) begin
        if (!ser_rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= bus_s[0];
            sda_q <= bus_s[1];
        end
    end

    assign scl_rise  = bus_s[0] & ~scl_q;
    assign scl_fall  = ~bus_s[0] & scl_q;
    assign start_det = bus_s[0] & scl_q & sda_q & ~bus_s[1];
    assign stop_det  = bus_s[0] & scl_q & ~sda_q & bus_s[1];

    // Serial slave state machine, reset by select low
    always_ff @(posedge CLOCK or negedge ser_rst_n) begin
        if (!ser_rst_n) begin
            st_r        <= SER_IDLE;
            ack_next_r  <= SER_SUB;
            bitcnt_r    <= 3'h0;
            shift_r     <= 8'h00;
            tx_r        <= 8'h00;
            sub_r       <= 8'h00;
            nack_r      <= 1'b0;
            sda_drive_r <= 1'b0;
            addr_bit_r  <= 1'b0;
        end else if (start_det) begin
            st_r        <= SER_ADDR;
            bitcnt_r    <= 3'h0;
            sda_drive_r <= 1'b0;
            addr_bit_r  <= 1'b0;
        end else if (stop_det) begin
            st_r        <= SER_IDLE;
            sda_drive_r <= 1'b0;
        end else if (scl_rise) begin
            if (st_r inside {SER_ADDR, SER_SUB, SER_DATA}) begin
                shift_r  <= {shift_r[6:0], bus_s[1]};
                bitcnt_r <= bitcnt_r + 3'h1;
                addr_bit_r <= 1'b1;
            end else if (st_r == SER_READ) begin
                bitcnt_r <= bitcnt_r + 3'h1;
            end else if (st_r == SER_RACK) begin
                nack_r <= bus_s[1];
            end
        end else if (scl_fall) begin
            unique case (st_r)
                SER_IDLE: begin
                    sda_drive_r <= 1'b0;
                end
                SER_ADDR: begin
                    // First fall after a start carries no address bit yet
                    if (bitcnt_r == 3'h0 && addr_bit_r) begin
                        if (shift_r[7:1] == DEV_ADDR) begin
                            sda_drive_r <= 1'b1;
                            st_r        <= SER_ACK;
                            ack_next_r  <= shift_r[0] ? SER_READ : SER_SUB;
                        end else begin
                            st_r <= SER_IDLE;
                        end
                    end
                end
                SER_SUB: begin
                    if (bitcnt_r == 3'h0) begin
                        sub_r       <= shift_r;
                        sda_drive_r <= 1'b1;
                        st_r        <= SER_ACK;
                        ack_next_r  <= SER_DATA;
                    end
                end
                SER_DATA: begin
                    if (bitcnt_r == 3'h0) begin
                        sub_r       <= sub_r + 8'h01;
                        sda_drive_r <= 1'b1;
                        st_r        <= SER_ACK;
                        ack_next_r  <= SER_DATA;
                    end
                end
                SER_ACK: begin
                    bitcnt_r <= 3'h0;
                    if (ack_next_r == SER_READ) begin
                        tx_r        <= rd_sub;
                        sub_r       <= sub_r + 8'h01;
                        sda_drive_r <= ~rd_sub[7];
                    end else begin
                        sda_drive_r <= 1'b0;
                    end
                    st_r <= ack_next_r;
                end
                SER_READ: begin
                    if (bitcnt_r == 3'h0) begin
                        sda_drive_r <= 1'b0;
                        st_r        <= SER_RACK;
                    end else begin
                        tx_r        <= {tx_r[6:0], 1'b0};
                        sda_drive_r <= ~tx_r[6];
                    end
                end
                SER_RACK: begin
                    if (nack_r) begin
                        st_r <= SER_IDLE;
                    end else begin
                        tx_r        <= rd_byte(sub_r);
                        sub_r       <= sub_r + 8'h01;
                        sda_drive_r <= ~rd_sub[7];
                        st_r        <= SER_READ;
                    end
                end
                default: begin
                    st_r        <= SER_IDLE;
                    sda_drive_r <= 1'b0;
                end
            endcase
        end
    end

    // Serial write lands when a data byte completes; it wins over the port
    assign ser_wr  = scl_fall & ~start_det & ~stop_det & (st_r == SER_DATA)
                     & (bitcnt_r == 3'h0);
    assign wr_en   = ser_wr | REG_WR;
    assign wr_addr = ser_wr ? sub_r : REG_ADDR;
    assign wr_data = ser_wr ? shift_r : REG_WDATA;

    // Powered-down default, defaults on every serial reset
    always_ff @(posedge CLOCK or negedge ser_rst_n) begin
        if (!ser_rst_n) begin
            ctl_r <= CTL_RST;
        end else if (wr_en && wr_addr == OFS_CTL) begin
            ctl_r <= wr_data;
        end
    end

    always_ff @(posedge CLOCK or negedge ser_rst_n) begin
        if (!ser_rst_n) begin
            trim_r <= TRIM_RST;
        end else if (wr_en && wr_addr == OFS_TRIM) begin
            trim_r <= wr_data[TRIM_W-1:0];
        end
    end

    always_ff @(posedge CLOCK or negedge ser_rst_n) begin
        if (!ser_rst_n) begin
            out_r <= OUT_RST;
        end else if (wr_en && wr_addr == OFS_OUT) begin
            out_r <= wr_data;
        end
    end

    // Unmapped offsets read zero
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            REG_RDATA <= rd_byte(REG_ADDR);
        end else begin
            REG_RDATA <= 8'h00;
        end
    end

    // Differential only with 12-bit bus and low-swing reference
    assign pin_diff = pins_s[PIN_CLOCK_MODE_SELECT] & ~pins_s[PIN_BUS_WIDTH_SELECT] & pins_s[PIN_VREFL];

    // Configuration outputs: pin mode versus serial mode
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            CFG_LATCH_RISING  <= 1'b0;
            CFG_BUS_24BIT     <= 1'b0;
            CFG_CLOCK_DIFF    <= 1'b0;
            CFG_DESKEW_EN     <= 1'b0;
            CFG_DESKEW_TRIM   <= TRIM_RST;
            CORE_ENABLE       <= 1'b0;
            HOT_PLUG_DETECTED <= 1'b0;
            SERIAL_ACTIVE     <= 1'b0;
        end else if (interface_select_s && INTERFACE_SELECT) begin
            SERIAL_ACTIVE     <= 1'b1;
            CFG_LATCH_RISING  <= ctl_r[CTL_EDGE_BIT];
            CFG_BUS_24BIT     <= ctl_r[CTL_BUS24_BIT];
            CFG_CLOCK_DIFF    <= ctl_r[CTL_DIFF_BIT];
            CFG_DESKEW_EN     <= ctl_r[CTL_DESKEW_BIT];
            CFG_DESKEW_TRIM   <= ctl_r[CTL_DESKEW_BIT] ? trim_r : TRIM_RST;
            CORE_ENABLE       <= ctl_r[CTL_PWR_UP_BIT];
            HOT_PLUG_DETECTED <= pins_s[PIN_EDGE];
        end else begin
            SERIAL_ACTIVE     <= 1'b0;
            // Edge select for both clock styles
            CFG_LATCH_RISING  <= pins_s[PIN_EDGE];
            CFG_BUS_24BIT     <= pins_s[PIN_BUS_WIDTH_SELECT];
            CFG_CLOCK_DIFF    <= pin_diff;
            CFG_DESKEW_EN     <= pins_s[PIN_DESKEW_ENABLE_PIN];
            CFG_DESKEW_TRIM   <= pins_s[PIN_DESKEW_ENABLE_PIN] ? pins_s[PIN_TRIM +: TRIM_W] : TRIM_RST;
            // Power-down strap gates the core only
            CORE_ENABLE       <= pins_s[PIN_PDN];
            HOT_PLUG_DETECTED <= 1'b0;
        end
    end

    // Serial data pin is open-drain, never driven high
    always_ff @(posedge CLOCK or negedge ser_rst_n) begin
        if (!ser_rst_n) begin
            CLOCK_MODE_SDA_O  <= 1'b0;
            CLOCK_MODE_SDA_OE <= 1'b0;
        end else begin
            CLOCK_MODE_SDA_O  <= 1'b0;
            CLOCK_MODE_SDA_OE <= sda_drive_r & ~start_det & ~stop_det;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            MONITOR_SENSE_OUT_O  <= 1'b0;
            MONITOR_SENSE_OUT_OE <= 1'b0;
        end else begin
            MONITOR_SENSE_OUT_O <= 1'b0;
            if (interface_select_s && INTERFACE_SELECT) begin
                MONITOR_SENSE_OUT_OE <= ~out_r[OUT_PROG_BIT];
            end else begin
                MONITOR_SENSE_OUT_OE <= ~pins_s[PIN_RXDET];
            end
        end
    end

endmodule // cms_ctrl

// >>> test/cms_ctrl_properties.sv
// Purpose: Port-level properties of the configuration mode select block
// Assumes: One clock domain; strap effects lag pins by three edges
// Notes:   Pin-mode checks wait until the pin path has refilled
`timescale 1ns/1ps
module cms_ctrl_check (
    input logic                       CLOCK,
    input logic                       RESET_N,
    input logic                       INTERFACE_SELECT,
    input logic                       LATCH_EDGE_HOT_PLUG,
    input logic                       BUS_WIDTH_SCL,
    input logic                       CLOCK_MODE_SDA_I,
    input logic                       CLOCK_MODE_SDA_O,
    input logic                       CLOCK_MODE_SDA_OE,
    input logic                       POWER_DOWN_N,
    input logic                       VREF_LOW_SWING,
    input logic                       RECEIVER_DETECT,
    input logic                       MONITOR_SENSE_OUT_O,
    input logic                       MONITOR_SENSE_OUT_OE,
    input logic [cms_pkg::REG_AW-1:0] REG_ADDR,
    input logic [cms_pkg::REG_DW-1:0] REG_WDATA,
    input logic                       REG_WR,
    input logic                       CFG_LATCH_RISING,
    input logic                       CFG_BUS_24BIT,
    input logic                       CFG_CLOCK_DIFF,
    input logic                       CORE_ENABLE,
    input logic                       SERIAL_ACTIVE
);
    import cms_pkg::*;
    logic [2:0] pin_cyc;
    logic [2:0] ser_cyc;
    logic       ctl_seen;
    logic       diff_pin;
    assign diff_pin = CLOCK_MODE_SDA_I && !BUS_WIDTH_SCL && VREF_LOW_SWING;
    // Saturating count of settled pin-mode cycles
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) pin_cyc <= 3'h0;
        else if (INTERFACE_SELECT) pin_cyc <= 3'h0;
        else if (pin_cyc != 3'h7) pin_cyc <= pin_cyc + 3'h1;
    end
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) ser_cyc <= 3'h0;
        else if (!INTERFACE_SELECT) ser_cyc <= 3'h0;
        else if (ser_cyc != 3'h7) ser_cyc <= ser_cyc + 3'h1;
    end
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) ctl_seen <= 1'b0;
        else if (!INTERFACE_SELECT) ctl_seen <= 1'b0;
        else if (REG_WR && REG_ADDR == OFS_CTL) ctl_seen <= 1'b1;
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    sequence s_ctl_wr; REG_WR && INTERFACE_SELECT && REG_ADDR == OFS_CTL; endsequence
    sequence s_out_wr; REG_WR && INTERFACE_SELECT && REG_ADDR == OFS_OUT; endsequence
    sequence s_quiet3; (INTERFACE_SELECT && !REG_WR)[*3]; endsequence
    a_sda_open_drain: assert property (!CLOCK_MODE_SDA_O)
        else $error("data line driven high");
    a_sense_open_drain: assert property (!MONITOR_SENSE_OUT_O)
        else $error("sense line driven high");
    a_pin_serial_off: assert property (pin_cyc >= 3'h4 |-> !SERIAL_ACTIVE && !CLOCK_MODE_SDA_OE)
        else $error("serial side alive in pin mode");
    a_pin_power_strap: assert property (pin_cyc >= 3'h6 |-> CORE_ENABLE == $past(POWER_DOWN_N, 3))
        else $error("core enable not following strap");
    a_pin_edge_strap: assert property (pin_cyc >= 3'h6 |-> CFG_LATCH_RISING == $past(LATCH_EDGE_HOT_PLUG, 3))
        else $error("latch edge not following strap");
    a_pin_width_strap: assert property (pin_cyc >= 3'h6 |-> CFG_BUS_24BIT == $past(BUS_WIDTH_SCL, 3))
        else $error("bus width not following strap");
    a_pin_clock_style: assert property (pin_cyc >= 3'h6 |-> CFG_CLOCK_DIFF == $past(diff_pin, 3))
        else $error("clock style wrong");
    a_pin_sense_rx: assert property (pin_cyc >= 3'h6 |-> MONITOR_SENSE_OUT_OE != $past(RECEIVER_DETECT, 3))
        else $error("sense not following receiver");
    a_ser_default_down: assert property (ser_cyc == 3'h6 && !ctl_seen |-> !CORE_ENABLE)
        else $error("not powered down on serial entry");
    a_ser_power_reg: assert property (s_ctl_wr ##1 s_quiet3 |-> CORE_ENABLE == $past(REG_WDATA[CTL_PWR_UP_BIT], 3))
        else $error("core enable not following register");
    a_ser_sense_reg: assert property (s_out_wr ##1 s_quiet3 |-> MONITOR_SENSE_OUT_OE != $past(REG_WDATA[OUT_PROG_BIT], 3))
        else $error("sense not following register");
endmodule // cms_ctrl_check

bind cms_ctrl cms_ctrl_check u_check (.CLOCK, .RESET_N, .INTERFACE_SELECT, .LATCH_EDGE_HOT_PLUG,
    .BUS_WIDTH_SCL, .CLOCK_MODE_SDA_I, .CLOCK_MODE_SDA_O, .CLOCK_MODE_SDA_OE, .POWER_DOWN_N,
    .VREF_LOW_SWING, .RECEIVER_DETECT, .MONITOR_SENSE_OUT_O, .MONITOR_SENSE_OUT_OE, .REG_ADDR,
    .REG_WDATA, .REG_WR, .CFG_LATCH_RISING, .CFG_BUS_24BIT, .CFG_CLOCK_DIFF, .CORE_ENABLE,
    .SERIAL_ACTIVE);

// >>> test/cms_host.sv
// Purpose: Two-wire serial host driving the shared strap pins
// Assumes: Pulled-up data line; each clock phase spans eight cycles
// Notes:   Clock stands high between frames; counts acks per transfer
`timescale 1ns/1ps
module cms_host (
    input  wire logic       clk,
    input  wire logic       sda,
    output logic            scl,
    output logic            sda_pull,
    output logic [7:0]      acks
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        acks = 8'h00;
    end
    task automatic hp(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic send(input logic [7:0] b);
        for (int j = 7; j >= 0; j--) begin
            sda_pull <= !b[j];
            hp(6);
            scl <= 1'b1;
            hp(8);
            scl <= 1'b0;
            hp(2);
        end
        // Release for the slave's acknowledge
        sda_pull <= 1'b0;
        hp(6);
        scl <= 1'b1;
        hp(4);
        if (sda === 1'b0) acks = acks + 8'h01;
        hp(4);
        scl <= 1'b0;
        hp(2);
    endtask
    task automatic xfer(input logic [7:0] dev, input logic [7:0] sub, input logic [7:0] d);
        acks = 8'h00;
        hp(1);
        sda_pull <= 1'b1;
        hp(8);
        scl <= 1'b0;
        hp(2);
        send(dev);
        send(sub);
        send(d);
        sda_pull <= 1'b1;
        hp(6);
        scl <= 1'b1;
        hp(8);
        sda_pull <= 1'b0;
        hp(8);
    endtask
endmodule // cms_host

// >>> test/cms_ctrl_test.sv
// Purpose: Self-checking bench for the configuration mode select block
// Assumes: Strap and register results settle within six cycles
// Notes:   Serial pins are muxed between host model and straps by mode
`timescale 1ns/1ps
module cms_ctrl_test;
    import cms_pkg::*;
    localparam logic [6:0] DEV = 7'h38;
    logic clock, reset_n, sel, edge_hp, bus_width_select, clock_mode_select, pdn, deskew_enable_pin, vref, rxdet, wr, rd;
    logic [TRIM_W-1:0] trim, cfg_trim;
    logic [7:0] addr, wdata, rdata;
    logic sda_o, sda_oe, monitor_sense_out_o, monitor_sense_out_oe, cfg_rise, cfg_24, cfg_diff, cfg_dk, core_en, hpd, ser;
    logic scl, sda_pull, scl_wire, sda_wire;
    int num_errors, checks;
    assign scl_wire = sel ? scl : bus_width_select;
    assign sda_wire = sel ? !(sda_pull || sda_oe) : clock_mode_select;
    cms_ctrl #(.DEV_ADDR(DEV)) DUT (.CLOCK(clock), .RESET_N(reset_n), .INTERFACE_SELECT(sel),
        .LATCH_EDGE_HOT_PLUG(edge_hp), .BUS_WIDTH_SCL(scl_wire), .CLOCK_MODE_SDA_I(sda_wire),
        .CLOCK_MODE_SDA_O(sda_o), .CLOCK_MODE_SDA_OE(sda_oe), .POWER_DOWN_N(pdn),
        .DESKEW_ENABLE_PIN(deskew_enable_pin), .DESKEW_TRIM_PINS(trim), .VREF_LOW_SWING(vref),
        .RECEIVER_DETECT(rxdet), .MONITOR_SENSE_OUT_O(monitor_sense_out_o), .MONITOR_SENSE_OUT_OE(monitor_sense_out_oe),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
        .CFG_LATCH_RISING(cfg_rise), .CFG_BUS_24BIT(cfg_24), .CFG_CLOCK_DIFF(cfg_diff),
        .CFG_DESKEW_EN(cfg_dk), .CFG_DESKEW_TRIM(cfg_trim), .CORE_ENABLE(core_en),
        .HOT_PLUG_DETECTED(hpd), .SERIAL_ACTIVE(ser));
    cms_host host (.clk(clock), .sda(sda_wire), .scl(scl), .sda_pull(sda_pull), .acks());
    initial begin
        clock = 1'b0;
        forever #10 clock = !clock;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic chk1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: bit %b want %b", $time, got, exp);
        end
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: byte %h want %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        chk8(rdata, exp);
    endtask
    task automatic test_done();
        if (num_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        cyc(6000);
        num_errors++;
        test_done();
    end
    initial begin
        logic [3:0] v;
        {reset_n, sel, edge_hp, bus_width_select, clock_mode_select, pdn, deskew_enable_pin, vref, rxdet, wr, rd} = 11'h000;
        trim = 3'h0;
        addr = 8'h00;
        wdata = 8'h00;
        cyc(5);
        reset_n <= 1'b1;
        // Walk strap combinations, diff clock included
        for (int i = 0; i < 16; i++) begin
            v = i[3:0];
            @(posedge clock);
            {vref, clock_mode_select, bus_width_select, edge_hp} <= v;
            pdn <= !v[0];
            deskew_enable_pin <= v[1] ^ v[3];
            rxdet <= v[2] ^ v[0];
            trim <= v[2:0];
            cyc(6);
            chk1(cfg_rise, v[0]);
            chk1(cfg_24, v[1]);
            chk1(cfg_diff, v[2] & !v[1] & v[3]);
            chk1(core_en, !v[0]);
            chk1(monitor_sense_out_oe, !(v[2] ^ v[0]));
            chk1(cfg_dk, v[1] ^ v[3]);
            chk8({5'h00, cfg_trim}, (v[1] ^ v[3]) ? {5'h00, v[2:0]} : {5'h00, TRIM_RST});
            chk1(ser, 1'b0);
        end
        reg_wr(OFS_CTL, 8'h01);
        cyc(5);
        chk1(core_en, 1'b0);
        @(posedge clock);
        sel <= 1'b1;
        // Board ties the power strap low in serial mode
        pdn <= 1'b0;
        edge_hp <= 1'b0;
        rxdet <= 1'b0;
        cyc(8);
        chk1(ser, 1'b1);
        chk1(core_en, 1'b0);
        chk1(monitor_sense_out_oe, 1'b1);
        rd_chk(OFS_CTL, CTL_RST);
        rd_chk(OFS_TRIM, {5'h00, TRIM_RST});
        reg_wr(OFS_TRIM, 8'h02);
        reg_wr(OFS_CTL, 8'h1D);
        @(posedge clock);
        edge_hp <= 1'b1;
        rxdet <= 1'b1;
        cyc(6);
        chk1(core_en, 1'b1);
        chk1(cfg_rise, 1'b0);
        chk1(hpd, 1'b1);
        chk1(cfg_24 & cfg_diff & cfg_dk, 1'b1);
        chk8({5'h00, cfg_trim}, 8'h02);
        chk1(monitor_sense_out_oe, 1'b1);
        rd_chk(OFS_STAT, 8'h03);
        rd_chk(OFS_CTL, 8'h1D);
        rd_chk(8'h00, 8'h00);
        rd_chk(8'h0C, 8'h00);
        host.xfer({DEV, 1'b0}, OFS_OUT, 8'h01);
        chk8(host.acks, 8'h03);
        chk1(monitor_sense_out_oe, 1'b0);
        host.xfer({DEV ^ 7'h01, 1'b0}, OFS_OUT, 8'h00);
        chk8(host.acks, 8'h00);
        chk1(monitor_sense_out_oe, 1'b0);
        reg_wr(OFS_OUT, 8'h00);
        cyc(2);
        chk1(monitor_sense_out_oe, 1'b1);
        reg_wr(OFS_OUT, 8'h01);
        cyc(4);
        chk1(monitor_sense_out_oe, 1'b0);
        @(posedge clock);
        sel <= 1'b0;
        cyc(3);
        sel <= 1'b1;
        cyc(8);
        chk1(core_en, 1'b0);
        chk1(monitor_sense_out_oe, 1'b1);
        rd_chk(OFS_CTL, CTL_RST);
        rd_chk(OFS_TRIM, {5'h00, TRIM_RST});
        test_done();
    end
endmodule // cms_ctrl_test
